// *** rtl/dpas_pkg.sv ***
// Purpose: Shared constants and types for the dual phase accumulator synth
// Assumes: 8-bit write-only processor port, 5-bit address
// Notes:   Offsets follow the per-channel register map
package dpas_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int ACC_W   = 32;
    localparam int LUT_W   = 16;
    localparam int OUT_W   = 12;
    localparam int PM_W    = 3;
    localparam int ADDR_W  = 5;
    localparam int DATA_W  = 8;
    localparam int CTRL_W  = 8;

    // ****************************************
    // Register offsets within one channel
    // ****************************************
    localparam logic [3:0] OFS_INC_A0  = 4'h0;
    localparam logic [3:0] OFS_INC_B0  = 4'h4;
    localparam logic [3:0] OFS_SYNC    = 4'h8;
    localparam logic [3:0] OFS_ASYNC   = 4'hA;
    localparam logic [3:0] OFS_ACC_RST = 4'hC;
    localparam logic [3:0] OFS_HOP     = 4'hE;

    // ****************************************
    // Control fields and reset values
    // ****************************************
    localparam int SYNC_EXT_PM_EN  = 0;
    localparam int SYNC_EXT_MUX_EN = 1;
    localparam int ASYNC_NR_EN     = 0;
    localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
    localparam logic [ACC_W-1:0]  INC_RST  = 32'h0000_0000;

    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } dpas_wr_t;

    typedef struct packed {
        logic [ACC_W-1:0]  inc_a;
        logic [ACC_W-1:0]  inc_b;
        logic [CTRL_W-1:0] sync_ctl;
    } dpas_buf_t;

endpackage : dpas_pkg

// *** rtl/dpas_top.sv ***
// Purpose: Two independent phase accumulator sine synth channels
// Assumes: One clock, synchronous active-low reset, write-only port
// Notes:   Channel index taken from address bit 4
//
// Contract
// - Two independent channels share one processor write interface.
// - Each channel has increments A and B, chosen by an external select.
// - Accumulator and both increments are 32 bits wide.
// - A 3-bit external phase modulation input offsets the phase.
// - Synchronous inputs allow phase and frequency modulation.
// - Sync mode control is shadowed and made active on hop strobe.
// - Increments may be written anytime; active only after hop.
// - Async hop command write transfers shadows like the hop strobe.
// - Async mode control acts as soon as written.
// - Selected increment added to accumulator every clock.
// - Phase converted to sine amplitude once per clock.
// - Optional noise reduction stage before the channel output.
// - Output frequency equals clock times increment over two to 32.
// - Channels independent; no relationship unless software makes one.
// - Only the top 16 phase bits feed the sine lookup.
// - Lookup delivers the top 12 amplitude bits.
// - Registers write-only, decoded from 5-bit address, select, write.
`timescale 1ns/10ps
module dpas_top
    import dpas_pkg::*;
#(
    parameter int NCH = 2
) (
    input  wire logic                       clock,
    input  wire logic                       rstn,
    input  wire logic                       clk_en,
    input  wire logic                       cs_n,
    input  wire logic                       wr_n,
    input  wire logic [ADDR_W-1:0]          addr,
    input  wire logic [DATA_W-1:0]          wdata,
    input  wire logic [NCH-1:0]             hop_strobe,
    input  wire logic [NCH-1:0]             inc_select,
    input  wire logic [NCH-1:0][PM_W-1:0]   ext_phase_mod,
    output logic      [NCH-1:0][OUT_W-1:0]  sine_out
);

    // ****************************************
    // Pin synchronisers and write decode
    // ****************************************
    localparam int PIN_W = 2 + ADDR_W + DATA_W + NCH * (2 + PM_W);
    // Idle pin levels: cs_n and wr_n high, all else low, hop strobes included
    localparam logic [PIN_W-1:0] PIN_IDLE = {2'b11, {(PIN_W-2){1'b0}}};
    logic [PIN_W-1:0] pin_s1_reg;
    logic [PIN_W-1:0] pin_s2_reg;
    logic             wr_seen_reg;

    wire logic [PIN_W-1:0] pin_raw = {cs_n, wr_n, addr, wdata,
                                      hop_strobe, inc_select, ext_phase_mod};

    // Fields of the second stage only
    wire logic                     cs_s  = pin_s2_reg[PIN_W-1];
    wire logic                     wr_s  = pin_s2_reg[PIN_W-2];
    wire logic [ADDR_W-1:0]        adr_s =
        pin_s2_reg[PIN_W-3 -: ADDR_W];
    wire logic [DATA_W-1:0]        dat_s =
        pin_s2_reg[PIN_W-3-ADDR_W -: DATA_W];
    wire logic [NCH-1:0]           hop_s =
        pin_s2_reg[NCH*(1+PM_W) +: NCH];
    wire logic [NCH-1:0]           sel_s = pin_s2_reg[NCH*PM_W +: NCH];
    wire logic [NCH*PM_W-1:0]      pm_s  = pin_s2_reg[NCH*PM_W-1:0];
    wire logic wr_act = !cs_s && !wr_s;
    // Single write per strobe: act on the leading edge only
    wire logic wr_edge = wr_act && !wr_seen_reg;
    wire dpas_wr_t wr_bus = '{wr: wr_edge, addr: adr_s, data: dat_s};

    // Idle reset values: no false hop or write after reset
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pin_s1_reg  <= PIN_IDLE;
            pin_s2_reg  <= PIN_IDLE;
            wr_seen_reg <= 1'b0;
        end else if (clk_en) begin
            pin_s1_reg  <= pin_raw;
            pin_s2_reg  <= pin_s1_reg;
            wr_seen_reg <= wr_act;
        end
    end

    // Offset decode shared by both channels
    function automatic logic hit(input dpas_wr_t w, input int ch,
                                 input logic [3:0] ofs);
        hit = w.wr && (w.addr[ADDR_W-1] == ch[0]) && (w.addr[3:0] == ofs);
    endfunction : hit

    // ****************************************
    // Quarter-wave sine table
    // ****************************************
    localparam int QA_W = LUT_W - 2;
    function automatic logic [OUT_W-2:0] qsine(input logic [QA_W-1:0] a);
        real x;
        x = $sin(3.14159265358979 / 2.0 * (real'(a) + 0.5)
                 / real'(1 << QA_W));
        qsine = (OUT_W-1)'($rtoi(x * real'((1 << (OUT_W-1)) - 1)));
    endfunction : qsine

    logic [OUT_W-2:0] sine_rom [0:(1<<QA_W)-1];
    initial begin
        for (int i = 0; i < (1 << QA_W); i++) begin
            sine_rom[i] = qsine(QA_W'(i));
        end
    end

    // ****************************************
    // Dither generator taps
    // ****************************************
    // Feedback taps of the dither shift register
    localparam int LFSR_T0 = OUT_W - 1;
    localparam int LFSR_T1 = OUT_W - 2;
    localparam int LFSR_T2 = OUT_W - 3;
    localparam int LFSR_T3 = 3;

    // ****************************************
    // Channels
    // ****************************************
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        dpas_buf_t         shadow_reg;
        dpas_buf_t         active_reg;
        logic [CTRL_W-1:0] async_ctl_reg;
        logic [ACC_W-1:0]  acc_reg;
        logic [OUT_W-1:0]  amp_reg;
        logic [OUT_W-1:0]  out_reg;
        logic [OUT_W-1:0]  lfsr_reg;
        dpas_buf_t         shadow_next;

        // Writes decoded for this channel; clear, hop and async writes act at once, sync and increment writes wait for a hop
        wire logic acc_clr = hit(wr_bus, c, OFS_ACC_RST);
        wire logic hop_cmd = hit(wr_bus, c, OFS_HOP);
        wire logic do_hop  = hop_s[c] || hop_cmd;
        wire logic async_wr = hit(wr_bus, c, OFS_ASYNC);
        wire logic sync_wr  = hit(wr_bus, c, OFS_SYNC);

        // Shadow bytes land as written; active waits for a hop
        always_comb begin
            shadow_next = shadow_reg;
            for (int b = 0; b < ACC_W / DATA_W; b++) begin
                if (hit(wr_bus, c, OFS_INC_A0 + 4'(b))) begin
                    shadow_next.inc_a[b*DATA_W +: DATA_W] = dat_s;
                end
                if (hit(wr_bus, c, OFS_INC_B0 + 4'(b))) begin
                    shadow_next.inc_b[b*DATA_W +: DATA_W] = dat_s;
                end
            end
            if (sync_wr) begin
                shadow_next.sync_ctl = dat_s;
            end
        end

        // ****************************************
        // Increment select and phase offset
        // ****************************************
        // External select only when sync control enables it
        wire logic use_b = active_reg.sync_ctl[SYNC_EXT_MUX_EN] ?
                           sel_s[c] : 1'b0;
        wire logic [ACC_W-1:0] inc_sel = use_b ? active_reg.inc_b
                                               : active_reg.inc_a;
        wire logic [PM_W-1:0] pm = active_reg.sync_ctl[SYNC_EXT_PM_EN] ?
                                   pm_s[c*PM_W +: PM_W] : '0;
        // Offset in top phase bits; low bits truncated
        wire logic [LUT_W-1:0] ph = acc_reg[ACC_W-1 -: LUT_W]
            + {pm, {(LUT_W-PM_W){1'b0}}};

        // ****************************************
        // Quarter-wave fold and sign
        // ****************************************
        wire logic [QA_W-1:0] qa = ph[LUT_W-2] ? ~ph[QA_W-1:0]
                                               : ph[QA_W-1:0];
        wire logic [OUT_W-2:0] mag = sine_rom[qa];
        wire logic [OUT_W-1:0] amp = ph[LUT_W-1] ? ~{1'b0, mag}
                                                 : {1'b0, mag};

        // ****************************************
        // Noise reduction on the registered amplitude
        // ****************************************
        // Dither one LSB to break periodic quantisation error
        wire logic nr_on = async_ctl_reg[ASYNC_NR_EN];
        // Top code never dithered, so the word cannot wrap negative
        wire logic nr_top = amp_reg == {1'b0, {(OUT_W-1){1'b1}}};
        wire logic nr_add = nr_on && lfsr_reg[0] && !nr_top;
        wire logic [OUT_W-1:0] nr_out = amp_reg
            + {{(OUT_W-1){1'b0}}, nr_add};
        wire logic fb = lfsr_reg[LFSR_T0] ^ lfsr_reg[LFSR_T1]
                        ^ lfsr_reg[LFSR_T2] ^ lfsr_reg[LFSR_T3];

        always_ff @(posedge clock) begin
            if (!rstn) begin
                shadow_reg    <= '{INC_RST, INC_RST, CTRL_RST};
                active_reg    <= '{INC_RST, INC_RST, CTRL_RST};
                async_ctl_reg <= CTRL_RST;
                acc_reg       <= INC_RST;
                amp_reg       <= '0;
                out_reg       <= '0;
                lfsr_reg      <= {{(OUT_W-1){1'b0}}, 1'b1};
            end else if (clk_en) begin
                shadow_reg <= shadow_next;
                if (do_hop) begin
                    active_reg <= shadow_next;
                end
                if (async_wr) begin
                    async_ctl_reg <= dat_s;
                end
                // Wraps modulo 2^32; step is clock over 2^32
                acc_reg  <= acc_clr ? INC_RST
                                    : acc_reg + inc_sel;
                // Two stages: amplitude, then dithered word
                amp_reg  <= amp;
                out_reg  <= nr_out;
                lfsr_reg <= {lfsr_reg[OUT_W-2:0], fb};
            end
        end

        assign sine_out[c] = out_reg;
    end

endmodule : dpas_top

// *** test/dpas_chk.sv ***
// Purpose: Port checker for dpas_top
// Assumes: One clock, rstn synchronous active low
// Notes:   Bound to the top after the module
`timescale 1ns/10ps
module dpas_chk
    import dpas_pkg::*;
#(
    parameter int NCH = 2
) (
    input wire logic                      clock,
    input wire logic                      rstn,
    input wire logic                      clk_en,
    input wire logic                      cs_n,
    input wire logic                      wr_n,
    input wire logic [ADDR_W-1:0]         addr,
    input wire logic [NCH-1:0]            hop_strobe,
    input wire logic [NCH-1:0][OUT_W-1:0] sine_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    wire             wr_act = !cs_n && !wr_n;
    // Writes acting without a hop: async ctl, clear, hop command
    wire             act_wr = wr_act && addr[3] && !addr[0] && |addr[2:1];
    // Counts to 7 after reset; sticks at 0 after hop or acting write
    logic [NCH-1:0][2:0] clean_reg;
    always_ff @(posedge clock) begin
        for (int c = 0; c < NCH; c++) begin
            if (!rstn)
                clean_reg[c] <= 3'h1;
            else if (hop_strobe[c] || (act_wr && addr[4] == c[0]))
                clean_reg[c] <= 3'h0;
            else if (clean_reg[c] != 3'h0 && clean_reg[c] != 3'h7)
                clean_reg[c] <= clean_reg[c] + 3'h1;
        end
    end
    sequence s_inc_wr; wr_act && !addr[4] && !addr[3]; endsequence
    sequence s_sync_wr;
        wr_act && !addr[4] && addr[3:0] == OFS_SYNC;
    endsequence
    property p_rst_zero;
        disable iff (1'b0) !rstn && clk_en |=> sine_out == '0;
    endproperty
    property p_release; $rose(rstn) && $past(clk_en) |-> sine_out == '0;
    endproperty
    property p_freeze; !clk_en |=> $stable(sine_out); endproperty
    property p_hold0; clean_reg[0] == 3'h7 |-> $stable(sine_out[0]);
    endproperty
    property p_hold1; clean_reg[1] == 3'h7 |-> $stable(sine_out[1]);
    endproperty
    property p_shadow;
        s_inc_wr ##0 clean_reg[0] == 3'h7 |=> $stable(sine_out[0])[*5];
    endproperty
    property p_sync_wr;
        s_sync_wr ##0 clean_reg[0] == 3'h7 |=> $stable(sine_out[0])[*5];
    endproperty
    property p_hop_other;
        hop_strobe[1] && clean_reg[0] == 3'h7 |=> $stable(sine_out[0])[*8];
    endproperty
    a_rst_zero: assert property (p_rst_zero)
        else $error("output not cleared by reset");
    a_release: assert property (p_release)
        else $error("output moved during reset");
    a_freeze: assert property (p_freeze)
        else $error("output moved while clock disabled");
    a_hold0: assert property (p_hold0)
        else $error("channel 0 moved without hop");
    a_hold1: assert property (p_hold1)
        else $error("channel 1 moved without hop");
    a_shadow: assert property (p_shadow)
        else $error("increment write acted before hop");
    a_sync_wr: assert property (p_sync_wr)
        else $error("sync control write acted before hop");
    a_hop_other: assert property (p_hop_other)
        else $error("hop on channel 1 disturbed channel 0");
endmodule : dpas_chk
bind dpas_top dpas_chk #(.NCH(NCH)) chk_u (.clock(clock), .rstn(rstn),
    .clk_en(clk_en), .cs_n(cs_n), .wr_n(wr_n), .addr(addr),
    .hop_strobe(hop_strobe), .sine_out(sine_out));

// *** test/dpas_dac_model.sv ***
// Purpose: DAC model latching one channel word per clock
// Assumes: DAC samples on the rising clock edge
// Notes:   Index 0 holds the newest sample
`timescale 1ns/10ps
module dpas_dac_model
    import dpas_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic [OUT_W-1:0]       code,
    output logic      [31:0][OUT_W-1:0] hist
);
    always_ff @(posedge clock) begin
        hist <= {hist[30:0], code};
    end
endmodule : dpas_dac_model

// *** test/dpas_top_test.sv ***
// Purpose: Self-checking bench for dpas_top
// Assumes: 20 MHz clock, inputs driven at falling edge
// Notes:   Expected shapes derived from increment steps of 1/16 turn
`timescale 1ns/10ps
module dpas_top_test;
    import dpas_pkg::*;
    logic clock = 1'b0;
    logic rstn, clk_en, cs_n, wr_n;
    logic [4:0] addr;
    logic [7:0] wdata;
    logic [1:0] hop_strobe, inc_select;
    logic [1:0][2:0] ext_phase_mod;
    logic [1:0][11:0] sine_out;
    logic [1:0][31:0][11:0] hist;
    logic [11:0] snap;
    int miscompares = 0, check_count = 0, cyc = 0, t0;
    int unsigned k;
    always #25 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    dpas_top #(.NCH(2)) dut_u (.clock(clock), .rstn(rstn), .clk_en(clk_en),
        .cs_n(cs_n), .wr_n(wr_n), .addr(addr), .wdata(wdata),
        .hop_strobe(hop_strobe), .inc_select(inc_select),
        .ext_phase_mod(ext_phase_mod), .sine_out(sine_out));
    dpas_dac_model dac0_u (.clock(clock), .code(sine_out[0]), .hist(hist[0]));
    dpas_dac_model dac1_u (.clock(clock), .code(sine_out[1]), .hist(hist[1]));
    task automatic chk(input string n, input logic [11:0] s, e);
        check_count++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge clock);
        {cs_n, wr_n, addr, wdata} = {2'b00, a, d};
        repeat (4) @(negedge clock);
        {cs_n, wr_n} = 2'b11;
        repeat (3) @(negedge clock);
    endtask : wr
    task automatic wr_inc(input logic c, b, input logic [31:0] v);
        for (int i = 0; i < 4; i++) wr({c, 1'b0, b, 2'(i)}, v[8*i +: 8]);
    endtask : wr_inc
    task automatic hop(input int c);
        @(negedge clock);
        hop_strobe[c] = 1'b1;
        @(negedge clock);
        hop_strobe[c] = 1'b0;
        repeat (4) @(negedge clock);
    endtask : hop
    // Cycles per repeat of the output for an increment of k/16 turn
    function automatic int period_of(input logic [2:0] k);
        period_of = 16 / int'(k & -k);
    endfunction : period_of
    task automatic per(input int c, input int p);
        chk("period", hist[c][0], hist[c][p]);
        chk("half turn", hist[c][p/2], ~hist[c][0]);
    endtask : per
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    initial begin
        {rstn, clk_en, cs_n, wr_n, addr, wdata} = {4'h7, 13'h0};
        {hop_strobe, inc_select, ext_phase_mod} = 10'h0;
        k = $urandom(32'hE0938BDD);
        repeat (3) @(negedge clock);
        chk("reset", sine_out[0], 12'h000);
        chk("reset 1", sine_out[1], 12'h000);
        rstn = 1'b1;
        wr_inc(1'b0, 1'b0, 32'h1000_0000);
        wr(5'h08, 8'h00);
        hop(1);
        repeat (10) @(negedge clock);
        chk("no hop", hist[0][0], hist[0][9]);
        hop(0);
        repeat (40) @(negedge clock);
        per(0, period_of(3'h1));
        chk("other", hist[1][0], hist[1][20]);
        wr(5'h18, 8'h02);
        inc_select[1] = 1'b1;
        repeat (4) begin
            k = $urandom_range(7, 1);
            wr_inc(1'b1, 1'b1, {4'(k), 28'h0});
            wr(5'h1E, 8'h00);
            repeat (40) @(negedge clock);
            per(1, period_of(3'(k)));
        end
        inc_select[1] = 1'b0;
        repeat (20) @(negedge clock);
        chk("select", hist[1][0], hist[1][1]);
        wr(5'h1C, 8'h00);
        repeat (10) @(negedge clock);
        chk("clear", hist[1][0], 12'h000);
        wr(5'h1A, 8'h01);
        repeat (20) @(negedge clock);
        t0 = 0;
        for (int i = 0; i < 16; i++) begin
            chk("dither step", hist[1][i] >> 1, 12'h000);
            t0 += int'(hist[1][i][0]);
        end
        chk("dither on", 12'(t0 != 0), 12'h001);
        ext_phase_mod[0] = 3'h4;
        repeat (20) @(negedge clock);
        {snap, t0} = {hist[0][0], cyc};
        wr(5'h08, 8'h01);
        hop(0);
        while ((cyc - t0) % 16 != 0 || cyc - t0 < 48) @(negedge clock);
        chk("offset", hist[0][0], ~snap);
        {clk_en, snap} = {1'b0, sine_out[0]};
        repeat (10) @(negedge clock);
        chk("freeze", sine_out[0], snap);
        clk_en = 1'b1;
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        give_verdict();
    end
endmodule : dpas_top_test
